//--- src/bcf_pkg.sv
package bcf_pkg;
   // --------------------------------------------------------------
   // Sequencer states and request kinds
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_T1 = 2'b01,
      ST_T2 = 2'b10
   } bcf_state_t;

   typedef enum logic [2:0] {
      K_MEM = 3'b000,
      K_PREF = 3'b001,
      K_IO = 3'b010,
      K_INTA = 3'b011,
      K_HALT = 3'b100
   } bcf_kind_t;

   typedef enum logic [1:0] {
      SZ32 = 2'b00,
      SZ16 = 2'b01,
      SZ8 = 2'b10
   } bcf_size_t;

   // Request length codes: up to one word, 8 bytes, 16 bytes
   localparam logic [1:0] LEN_WORD = 2'h0;
   localparam logic [1:0] LEN_DWORD = 2'h1;
   localparam logic [1:0] LEN_LINE = 2'h2;
   localparam logic [1:0] WORDS_M1_WORD = 2'h0;
   localparam logic [1:0] WORDS_M1_DWORD = 2'h1;
   localparam logic [1:0] WORDS_M1_LINE = 2'h3;
   localparam logic [3:0] BE_ALL = 4'hf;
   localparam logic [3:0] BE_NONE = 4'h0;

   // --------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_FILLS = 8'h08;
   localparam logic [7:0] REG_BURSTS = 8'h0c;
   localparam int CTRL_CE_BIT = 0;
   localparam int CTRL_PG_BIT = 1;
   localparam int CTRL_PCD_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Handshake pin group: ready, burst ready, cache enable, two sizes, data
   localparam int DATA_W = 32;
   localparam int HS_W = DATA_W + 5;
   localparam int HS_RDY = 32;
   localparam int HS_BURST_READY_N = 33;
   localparam int HS_KEN = 34;
   localparam int HS_BS8 = 35;
   localparam int HS_SIZE_HALF_WIDE_N = 36;
endpackage : bcf_pkg

//--- src/bcf_hs_if.sv
interface bcf_hs_if #(
   parameter int W = 37
);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport syncer (input raw, output sync);
   modport user (output raw, input sync);
endinterface : bcf_hs_if

//--- src/bcf_sync.sv
module bcf_sync #(
   parameter int W = 37
) (
   input wire logic clk,
   input wire logic rst,
   bcf_hs_if.syncer hs
);
   logic [W-1:0] meta;
   logic [W-1:0] stable;

   // Inactive-high reset value keeps the low-true handshakes idle
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (rst) begin
               meta[i] <= 1'b1;
               stable[i] <= 1'b1;
            end else begin
               meta[i] <= hs.raw[i];
               stable[i] <= meta[i];
            end
         end
      end
   endgenerate

   assign hs.sync = stable;
endmodule : bcf_sync

//--- src/bcf_order.sv
module bcf_order (
   input wire logic [1:0] first_word,
   input wire logic [1:0] index,
   output logic [1:0] word_sel
);
   // burst order
   // Index xor first word gives 0-4-8-c, 4-0-c-8, 8-c-0-4, c-8-4-0
   assign word_sel = first_word ^ index;
endmodule : bcf_order

//--- src/bcf_seq.sv
// How it works
// - Burst data: first item at second clock, then every clock.
// - Writes burst at most one 32-bit word, never several words.
// - Burst writes only while 8- or 16-bit sizing is returned.
// - Every transfer starts with address strobe; last flag inactive shows burst ability.
// - All burst addresses stay within one 16-byte aligned line.
// - Reads that are not line fills burst only the bytes the request needs.
// - Non-burstable cycles treat burst ready as normal ready.
// - Both readies active together: burst ready ignored, normal ending.
// - Last flag inactive until final cycle, active in final cycle.
// - Non-burst cycles begin with address strobe, end on normal ready.
// - Burst reads assert address strobe only in first cycle.
// - Once a line fill is chosen, whole line is fetched regardless of cache enable.
// - Fill data is cached only if cache enable is active in last cycle.
// - Cache enable ignored for writes and I/O; only memory reads fill.
// - Fill needs page cache disable clear, global cache enable, not locked/ack.
// - Fill chosen: last flag inactive, three more self-addressed cycles follow.
// - Word order is first address xor cycle index.
// - Normal ready inside a burst: new cycle with address strobe continues.
module bcf_seq
   import bcf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [bcf_pkg::REG_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [bcf_pkg::REG_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [31:0] req_addr,
   input wire logic [3:0] req_be,
   input wire logic [1:0] req_len,
   input wire logic req_write,
   input wire bcf_pkg::bcf_kind_t req_kind,
   input wire logic req_locked,
   input wire logic req_pcd,
   input wire logic [31:0] req_wdata,
   output logic rsp_valid,
   output logic [31:0] rsp_addr,
   output logic [31:0] rsp_data,
   output logic rsp_done,
   output logic rsp_cache_fill,
   output logic address_strobe_n,
   output logic [31:2] bus_addr,
   output logic [3:0] byte_en_n,
   output logic write_n,
   output logic last_transfer_flag_n,
   output logic [31:0] data_out,
   output logic data_oe,
   input wire logic [31:0] data_in,
   input wire logic ready_n,
   input wire logic burst_ready_n,
   input wire logic cacheable_input_n,
   input wire logic size_byte_wide_n,
   input wire logic size_half_wide_n
);
   import bcf_pkg::*;

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   bcf_hs_if #(.W(HS_W)) hs ();
   assign hs.raw = {size_half_wide_n, size_byte_wide_n, cacheable_input_n,
                    burst_ready_n, ready_n, data_in};

   bcf_sync #(.W(HS_W)) u_sync (
      .clk(clk),
      .rst(rst),
      .hs(hs)
   );

   logic s_rdy_n, s_burst_ready_n_n, s_ken_n, s_bs8_n, s_size_half_wide_n_n;
   logic [31:0] s_din;
   assign s_rdy_n = hs.sync[HS_RDY];
   assign s_burst_ready_n_n = hs.sync[HS_BURST_READY_N];
   assign s_ken_n = hs.sync[HS_KEN];
   assign s_bs8_n = hs.sync[HS_BS8];
   assign s_size_half_wide_n_n = hs.sync[HS_SIZE_HALF_WIDE_N];
   assign s_din = hs.sync[DATA_W-1:0];

   // Values of the previous clock, used when a ready arrives
   logic d_ken_n, d_bs8_n, d_size_half_wide_n_n;
   always_ff @(posedge clk) begin
      if (rst) begin
         d_ken_n <= 1'b1;
         d_bs8_n <= 1'b1;
         d_size_half_wide_n_n <= 1'b1;
      end else begin
         d_ken_n <= s_ken_n;
         d_bs8_n <= s_bs8_n;
         d_size_half_wide_n_n <= s_size_half_wide_n_n;
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Byte sizing wins when both size inputs are active
   function automatic bcf_size_t size_of(input logic bs8_n, input logic size_half_wide_n_n);
      if (!bs8_n) return SZ8;
      else if (!size_half_wide_n_n) return SZ16;
      else return SZ32;
   endfunction : size_of

   function automatic logic [3:0] piece_of(input logic [3:0] rem, input bcf_size_t sz);
      case (sz)
         SZ8: piece_of = rem & (~rem + 4'h1);
         SZ16: piece_of = (rem[1:0] != 2'b00) ? {2'b00, rem[1:0]} : {rem[3:2], 2'b00};
         default: piece_of = rem;
      endcase
   endfunction : piece_of

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [2:0] ctrl;
   logic [31:0] fill_cnt, burst_cnt;

   // ---------------------------------------------------------------
   // Transfer state
   // ---------------------------------------------------------------
   bcf_state_t state;
   logic [31:4] line;
   logic [1:0] first_w, widx, words_m1;
   logic [3:0] rem;
   logic [31:0] wbuf, wdat;
   bcf_kind_t kind;
   logic is_wr, can_fill, fill, first_dc;
   logic [1:0] cur_sel, nxt_sel;

   bcf_order u_ord_cur (.first_word(first_w), .index(widx), .word_sel(cur_sel));
   bcf_order u_ord_nxt (.first_word(first_w), .index(widx + 2'd1), .word_sel(nxt_sel));

   logic accept, take, hit_b, burst_cont, fill_now, word_done, xfer_done;
   logic [3:0] pm, rem_left, next_rem;
   logic [1:0] next_widx, last_idx;
   logic [31:0] next_wbuf;
   bcf_size_t szd;

   assign accept = req_valid && req_ready;
   assign szd = size_of(d_bs8_n, d_size_half_wide_n_n);

   always_comb begin
      hit_b = !s_burst_ready_n_n && s_rdy_n;
      take = (state == ST_T2) && (!s_rdy_n || hit_b);
      // no burst for ack/halt; sized writes only
      burst_cont = hit_b && kind != K_INTA && kind != K_HALT && (!is_wr || szd != SZ32);
      // fill latches once chosen; decided from last clock's cache enable
      fill_now = fill || (first_dc && can_fill && !d_ken_n);
      pm = piece_of(rem, szd);
      rem_left = rem & ~pm;
      last_idx = fill_now ? WORDS_M1_LINE : words_m1;
      word_done = (rem_left == BE_NONE) && !(fill_now && first_dc && rem != BE_ALL);
      xfer_done = word_done && (widx == last_idx);
      next_wbuf = wbuf;
      case (szd)
         SZ8: begin
            for (int b = 0; b < 4; b++) begin
               if (pm[b]) next_wbuf[8*b +: 8] = s_din[7:0];
            end
         end
         SZ16: begin
            if (pm[1:0] != 2'b00) next_wbuf[15:0] = s_din[15:0];
            else next_wbuf[31:16] = s_din[15:0];
         end
         default: next_wbuf = s_din;
      endcase
      next_rem = rem;
      next_widx = widx;
      if (take) begin
         if (word_done) begin
            next_rem = BE_ALL;
            next_widx = widx + 2'd1;
         end else if (fill_now && first_dc) begin
            // first fill word is completed as a whole word
            next_rem = BE_ALL & ~pm;
         end else begin
            next_rem = rem_left;
         end
      end
   end

   // Tentative last flag from current inputs, for the cycle that follows
   logic fill_t, last_t;
   logic [3:0] pm_t;
   always_comb begin
      fill_t = fill || (first_dc && can_fill && !s_ken_n && !take);
      if (take) fill_t = fill_now;
      pm_t = piece_of(next_rem, size_of(s_bs8_n, s_size_half_wide_n_n));
      if (fill_t && first_dc && !take) pm_t = BE_NONE;
      last_t = ((next_rem & ~pm_t) == BE_NONE)
               && (next_widx == (fill_t ? WORDS_M1_LINE : words_m1));
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         req_ready <= 1'b0;
         address_strobe_n <= 1'b1;
         last_transfer_flag_n <= 1'b1;
         bus_addr <= '0;
         byte_en_n <= BE_ALL;
         write_n <= 1'b1;
         data_oe <= 1'b0;
         data_out <= '0;
         line <= '0;
         first_w <= 2'd0;
         widx <= 2'd0;
         words_m1 <= WORDS_M1_WORD;
         rem <= BE_NONE;
         wdat <= '0;
         kind <= K_MEM;
         is_wr <= 1'b0;
         can_fill <= 1'b0;
         fill <= 1'b0;
         first_dc <= 1'b0;
      end else begin
         req_ready <= (state == ST_IDLE) && !accept;
         rem <= next_rem;
         widx <= next_widx;
         // flag tracks the final cycle; inactive while more may follow
         last_transfer_flag_n <= !last_t;
         case (state)
            ST_IDLE: begin
               if (accept) begin
                  // each cycle opens with the strobe
                  state <= ST_T1;
                  address_strobe_n <= 1'b0;
                  line <= req_addr[31:4];
                  first_w <= req_addr[3:2];
                  bus_addr <= req_addr[31:2];
                  byte_en_n <= ~req_be;
                  rem <= req_be;
                  widx <= 2'd0;
                  write_n <= !req_write;
                  data_oe <= req_write;
                  data_out <= req_wdata;
                  wdat <= req_wdata;
                  kind <= req_kind;
                  is_wr <= req_write;
                  // writes never span words; reads only what is asked
                  words_m1 <= (req_write || req_len == LEN_WORD) ? WORDS_M1_WORD :
                              (req_len == LEN_DWORD) ? WORDS_M1_DWORD : WORDS_M1_LINE;
                  can_fill <= !req_write && (req_kind == K_MEM || req_kind == K_PREF)
                              && !req_locked && ctrl[CTRL_CE_BIT]
                              && !(ctrl[CTRL_PG_BIT] ? req_pcd : ctrl[CTRL_PCD_BIT]);
                  fill <= 1'b0;
                  first_dc <= 1'b1;
               end
            end
            ST_T1: begin
               // ready ignored in the first clock
               state <= ST_T2;
               address_strobe_n <= 1'b1;
            end
            default: begin
               if (take) begin
                  first_dc <= 1'b0;
                  fill <= fill_now;
                  if (xfer_done) begin
                     state <= ST_IDLE;
                     data_oe <= 1'b0;
                     write_n <= 1'b1;
                  end else if (burst_cont) begin
                     // burst continues without a new strobe
                     state <= ST_T2;
                  end else begin
                     // normal ready: fresh cycle for the rest
                     state <= ST_T1;
                     address_strobe_n <= 1'b0;
                  end
                  bus_addr <= {line, word_done ? nxt_sel : cur_sel};
                  byte_en_n <= ~next_rem;
                  // Lanes below a sized piece mirror its bytes for narrow ports
                  data_out[15:0] <= (next_rem[1:0] != 2'b00) ? wdat[15:0] : wdat[31:16];
                  for (int b = 0; b < 4; b++) begin
                     if (next_rem[b] && (next_rem & ((4'h1 << b) - 4'h1)) == BE_NONE)
                        data_out[7:0] <= wdat[8*b +: 8];
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Answers to the core
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         wbuf <= '0;
         rsp_valid <= 1'b0;
         rsp_addr <= '0;
         rsp_data <= '0;
         rsp_done <= 1'b0;
         rsp_cache_fill <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         rsp_done <= 1'b0;
         rsp_cache_fill <= 1'b0;
         if (take) begin
            wbuf <= word_done ? '0 : next_wbuf;
            if (word_done && !is_wr) begin
               rsp_valid <= 1'b1;
               rsp_addr <= {line, cur_sel, 2'b00};
               rsp_data <= next_wbuf;
            end
            if (xfer_done) begin
               rsp_done <= 1'b1;
               // cache only with enable seen at the last cycle
               rsp_cache_fill <= fill_now && !d_ken_n;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   logic aw_got, w_got;
   logic [REG_AW-1:0] aw_a;
   logic [31:0] w_d;
   logic [3:0] w_s;

   function automatic logic [31:0] reg_read(input logic [REG_AW-1:0] a);
      if (a == REG_CTRL) return {29'h0, ctrl};
      else if (a == REG_STAT) return {26'h0, can_fill, fill, is_wr, first_dc, state};
      else if (a == REG_FILLS) return fill_cnt;
      else return burst_cnt;
   endfunction : reg_read

   function automatic logic reg_hit(input logic [REG_AW-1:0] a);
      return a == REG_CTRL || a == REG_STAT || a == REG_FILLS || a == REG_BURSTS;
   endfunction : reg_hit

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_a <= '0;
         w_d <= '0;
         w_s <= 4'h0;
         ctrl <= CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_a <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            w_d <= s_axi_wdata;
            w_s <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_got && w_got && !s_axi_bvalid) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_hit(aw_a) ? RESP_OKAY : RESP_SLVERR;
            if (aw_a == REG_CTRL && w_s[0]) ctrl <= w_d[2:0];
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= reg_hit(s_axi_araddr) ? reg_read(s_axi_araddr) : '0;
         s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Event counters for software
   always_ff @(posedge clk) begin
      if (rst) begin
         fill_cnt <= '0;
         burst_cnt <= '0;
      end else begin
         if (take && xfer_done && fill_now && !d_ken_n) fill_cnt <= fill_cnt + 32'h1;
         if (take && !xfer_done && burst_cont) burst_cnt <= burst_cnt + 32'h1;
      end
   end
endmodule : bcf_seq

//--- testbench/bcf_seq_props.sv
module bcf_seq_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic rsp_done,
   input wire logic rsp_cache_fill,
   input wire logic address_strobe_n,
   input wire logic [31:2] bus_addr,
   input wire logic write_n,
   input wire logic last_transfer_flag_n,
   input wire logic data_oe
);
   // ------------------------------------------------------------
   // Bus cycle properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   strobe_one_clock_a: assert property (!address_strobe_n |=> address_strobe_n)
      else $error("strobe held over one clock");
   strobe_when_busy_a: assert property (!address_strobe_n |-> !req_ready)
      else $error("strobe while idle");
   first_data_late_a: assert property (req_valid && req_ready |=> !rsp_done [*3])
      else $error("transfer ended too soon");
   done_pulse_a: assert property (rsp_done |=> !rsp_done)
      else $error("done longer than one clock");
   fill_on_read_a: assert property (rsp_cache_fill |-> rsp_done && write_n)
      else $error("fill flag without read completion");
   drive_on_write_a: assert property (data_oe |-> !write_n)
      else $error("data driven in a read");
   word_in_read_a: assert property (rsp_valid |-> write_n && !req_ready)
      else $error("read word outside a read");
   line_stable_a: assert property (!req_ready && !$past(req_ready) |->
      $stable(bus_addr[31:4])) else $error("address left its line");
   last_flag_a: assert property (rsp_valid || rsp_done |->
      $past(last_transfer_flag_n) != rsp_done) else $error("last flag wrong for this item");
endmodule : bcf_seq_props

bind bcf_seq bcf_seq_props bcf_seq_props_inst (.clk, .rst, .req_valid, .req_ready, .rsp_valid,
   .rsp_done, .rsp_cache_fill, .address_strobe_n, .bus_addr, .write_n, .data_oe,
   .last_transfer_flag_n);

//--- testbench/bcf_mem_model.sv
module bcf_mem_model (
   input wire logic clk,
   input wire logic busy,
   input wire logic [1:0] mode,
   input wire logic address_strobe_n,
   input wire logic [31:2] bus_addr,
   input wire logic write_n,
   input wire logic [31:0] data_out,
   output logic ready_n,
   output logic burst_ready_n,
   output logic [31:0] data_in,
   output logic [31:0] wseen
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Memory side: one slow item every six clocks
   // ------------------------------------------------------------
   // last flag unused
   initial begin
      ready_n = 1'b1;
      burst_ready_n = 1'b1;
      data_in = 32'h0;
      wseen = 32'h0;
      forever begin
         @(posedge clk);
         if (busy && !address_strobe_n) begin
            repeat (2) @(posedge clk);
            while (busy) begin
               data_in <= {~bus_addr[17:2], bus_addr[17:2]};
               if (!write_n) wseen <= data_out;
               // ready kind; mode 2 drives both on purpose
               ready_n <= mode[0] & ~mode[1];
               burst_ready_n <= ~(mode[0] | mode[1]);
               @(posedge clk);
               ready_n <= 1'b1;
               burst_ready_n <= 1'b1;
               // Released lines must not keep the old value
               data_in <= ~data_in;
               repeat (5) @(posedge clk);
            end
         end
      end
   end
endmodule : bcf_mem_model

//--- testbench/bcf_seq_tb_top.sv
module bcf_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bcf_pkg::*;
   logic clk, rst, busy, wr;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, req_addr, req_wdata, rsp_addr, rsp_data;
   logic [31:0] data_out, data_in, wseen, ctrl, d, r;
   logic [3:0] s_axi_wstrb, req_be, byte_en_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, req_len, mode, ln;
   logic req_valid, req_ready, req_write, req_locked, req_pcd, rsp_valid, rsp_done;
   logic rsp_cache_fill, address_strobe_n, write_n, last_transfer_flag_n, data_oe;
   logic ready_n, burst_ready_n, cacheable_input_n, size_byte_wide_n, size_half_wide_n;
   logic [31:2] bus_addr;
   bcf_kind_t req_kind;
   int seed, i, k;
   int failures = 0;
   int comparisons = 0;
   int fills = 0;

   bcf_seq bcf_seq_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready, .req_addr, .req_be, .req_len,
      .req_write, .req_kind, .req_locked, .req_pcd, .req_wdata, .rsp_valid, .rsp_addr, .rsp_data,
      .rsp_done, .rsp_cache_fill, .address_strobe_n, .bus_addr, .byte_en_n, .write_n,
      .last_transfer_flag_n, .data_out, .data_oe, .data_in, .ready_n, .burst_ready_n,
      .cacheable_input_n, .size_byte_wide_n, .size_half_wide_n);
   bcf_mem_model bcf_mem_model_inst (.clk, .busy, .mode, .address_strobe_n, .bus_addr, .write_n,
      .data_out, .ready_n, .burst_ready_n, .data_in, .wseen);

   // ------------------------------------------------------------
   // Checking helpers and bus tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] mem_word(input logic [31:0] a);
      return {~a[17:2], a[17:2]};
   endfunction : mem_word

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict;
      if (failures == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = 32'(s_axi_bresp);
            break;
         end
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = 32'(s_axi_rresp);
            break;
         end
      end
   endtask : axi_rd

   task automatic xfer(input int k, input logic [1:0] len, input logic wr, input logic [31:0] a);
      int seen;
      int stb;
      int nw;
      logic fill;
      logic [31:0] wd;
      fill = !wr && k < 2 && !req_locked && !cacheable_input_n && ctrl[0]
         && (ctrl[1] ? !req_pcd : !ctrl[2]);
      nw = (fill || len == LEN_LINE) ? 4 : (len == LEN_DWORD) ? 2 : 1;
      seen = 0;
      stb = 0;
      wd = $random(seed);
      req_kind <= bcf_kind_t'(k);
      req_len <= len;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= wd;
      req_valid <= 1'b1;
      repeat (600) begin
         @(posedge clk);
         if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            busy <= 1'b1;
         end
         if (!address_strobe_n) stb++;
         if (rsp_valid && k != 4) check(rsp_data, mem_word({a[31:4], a[3:2] ^ 2'(seen), 2'h0}));
         if (rsp_valid) check(rsp_addr, {a[31:4], a[3:2] ^ 2'(seen), 2'h0});
         if (rsp_valid) seen++;
         if (rsp_done) break;
      end
      busy <= 1'b0;
      check({31'h0, rsp_done}, 32'h1);
      check({31'h0, rsp_cache_fill}, {31'h0, fill});
      check(32'(stb), (wr || (mode == 2'h1 && k < 3)) ? 32'h1 : 32'(nw));
      if (k != 4) check(32'(seen), wr ? 32'h0 : 32'(nw));
      if (wr) check(wseen, wd);
      if (fill) fills++;
   endtask : xfer

   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      #1000000;
      failures++;
      print_verdict;
   end

   initial begin
      seed = 32'h93d0;
      {rst, busy, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h10;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {req_valid, req_write, req_locked, req_pcd} = 4'h0;
      {cacheable_input_n, size_byte_wide_n, size_half_wide_n} = 3'h7;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_addr, req_wdata} = '0;
      s_axi_wstrb = 4'hf;
      req_be = BE_ALL;
      req_len = LEN_WORD;
      req_kind = K_MEM;
      mode = 2'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      axi_rd(REG_CTRL);
      check(d, 32'(CTRL_RESET));
      axi_rd(8'h10);
      check(r, 32'(RESP_SLVERR));
      check(d, 32'h0);
      for (i = 0; i < 45; i++) begin
         if (i % 4 == 0) begin
            ctrl = (i == 0) ? 32'h1 : $random(seed) & 32'h7;
            axi_wr(REG_CTRL, ctrl);
            check(r, 32'(RESP_OKAY));
            axi_rd(REG_CTRL);
            check(d & 32'h7, ctrl);
         end
         k = i % 5;
         mode <= 2'(i % 3);
         cacheable_input_n <= (i < 2) ? 1'b0 : 1'($random(seed));
         req_locked <= ($random(seed) & 7) == 0;
         req_pcd <= 1'($random(seed));
         wr = (k == 0 || k == 2) ? 1'($random(seed)) : 1'b0;
         ln = (k < 2 && !wr) ? 2'($unsigned($random(seed)) % 3) : LEN_WORD;
         @(posedge clk);
         xfer(k, ln, wr, (i < 4) ? 32'h104 + 32'(4 * i) : $random(seed) & 32'h3fffc);
         repeat (8) @(posedge clk);
      end
      axi_rd(REG_FILLS);
      check(d, 32'(fills));
      print_verdict;
   end
endmodule : bcf_seq_tb_top
